// ===== dv/icar_bus_model.sv
// Far-side bus model: resolves the SCL wire with its pull-up and can stretch the clock.
`timescale 1ns/1ps
module icar_bus_model (
  input  wire logic scl_oe_i,
  input  wire logic stretch_i,
  output logic      scl_o
);
  logic       lclk     = 1'b0;
  logic [2:0] hold_cnt = 3'h0;

  // The far side runs from its own clock, eight times slower, so stretch ends always land on the block clock's falling edges.
  initial begin
    forever #40 lclk = ~lclk;
  end

  always @(posedge lclk) begin
    if (stretch_i && scl_oe_i) begin
      hold_cnt <= 3'h4;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end
  end

  // Released wire floats high through the pull-up.
  assign scl_o = !(scl_oe_i || hold_cnt != 3'h0);
endmodule

// ===== dv/icar_regs_test.sv
// Self-checking bench for the indirect count, address and rate register block.
`timescale 1ns/1ps
module icar_regs_test;
  import icar_pkg::*;
  localparam int T = 1;
  logic       clk_i = 0, rst_i = 1, ce_i = 1, ptr_wr_i = 0, data_wr_i = 0, data_rd_i = 0;
  logic       ctrl_wr_i = 0, master_i = 0, buffered_rx_i = 0, byte_stored_i = 0;
  logic       byte_sent_i = 0, addr_valid_i = 0, scl_i, scl_o, scl_oe_o, stretch = 0;
  logic       buffered_mode_o, count_invalid_o, count_done_irq_o, last_byte_ack_o;
  logic       own_match_o, gc_match_o;
  logic [7:0] wdata_i = 0, addr_byte_i = 0, rdata_o, ptr_o, a, av, v;
  logic       exp_own[$], exp_gc[$], exp_irq[$];
  logic [7:0] exp_rd[$];
  int         error_cnt = 0, n_compared = 0, cyc = 0, n;
  int         seed = 32'hC6D8F474;
  logic [7:0] cvals[5] = '{8'h00, 8'h01, 8'h44, 8'h45, 8'h7F};

  icar_regs #(.TICK_CYCLES(T)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .ptr_wr_i(ptr_wr_i), .data_wr_i(data_wr_i),
    .data_rd_i(data_rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ptr_o(ptr_o),
    .ctrl_wr_i(ctrl_wr_i), .master_i(master_i), .buffered_rx_i(buffered_rx_i),
    .byte_stored_i(byte_stored_i), .byte_sent_i(byte_sent_i), .addr_valid_i(addr_valid_i),
    .addr_byte_i(addr_byte_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .buffered_mode_o(buffered_mode_o), .count_invalid_o(count_invalid_o),
    .count_done_irq_o(count_done_irq_o), .last_byte_ack_o(last_byte_ack_o),
    .own_match_o(own_match_o), .gc_match_o(gc_match_o));

  icar_bus_model i_bus (.scl_oe_i(scl_oe_o), .stretch_i(stretch), .scl_o(scl_i));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] e);
    n_compared++;
    if (got !== e) begin
      error_cnt++;
      $display("BAD %0t read %h expected %h", $time, got, e);
    end
  endtask

  task automatic cmp1(input logic got, input logic e);
    n_compared++;
    if (got !== e) begin
      error_cnt++;
      $display("BAD %0t flag %b expected %b", $time, got, e);
    end
  endtask

  task automatic setptr(input logic [7:0] idx);
    @(negedge clk_i);
    ptr_wr_i = 1;
    wdata_i = idx;
    @(negedge clk_i);
    ptr_wr_i = 0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    setptr(idx);
    data_wr_i = 1;
    wdata_i = d;
    @(negedge clk_i);
    data_wr_i = 0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    setptr(idx);
    data_rd_i = 1;
    exp_rd.push_back(e);
    @(negedge clk_i);
    data_rd_i = 0;
  endtask

  task automatic ctrl(input logic m, input logic irq);
    @(negedge clk_i);
    ctrl_wr_i = 1;
    wdata_i = {7'h00, m};
    exp_irq.push_back(irq);
    @(negedge clk_i);
    ctrl_wr_i = 0;
  endtask

  task automatic addr(input logic [7:0] b, input logic eo, input logic eg);
    @(negedge clk_i);
    addr_valid_i = 1;
    addr_byte_i = b;
    exp_own.push_back(eo);
    exp_gc.push_back(eg);
    @(negedge clk_i);
    addr_valid_i = 0;
  endtask

  task automatic meas(input logic lvl, output int cnt);
    cnt = 0;
    while (scl_oe_o === lvl) @(negedge clk_i);
    while (scl_oe_o !== lvl) @(negedge clk_i);
    while (scl_oe_o === lvl) begin
      cnt++;
      @(negedge clk_i);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Results are registered at the edge that takes the strobe; pulses last one cycle only.
  always @(posedge clk_i) begin
    #1;
    if (data_rd_i && ce_i) begin
      cmp8(rdata_o, exp_rd.pop_front());
    end
    if (addr_valid_i && ce_i) begin
      cmp1(own_match_o, exp_own.pop_front());
      cmp1(gc_match_o, exp_gc.pop_front());
    end
    if (ctrl_wr_i && ce_i) begin
      cmp1(count_done_irq_o, exp_irq.pop_front());
    end
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(negedge clk_i);
    rst_i = 0;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'hE0);
    rd(8'h02, 8'h9D);
    rd(8'h03, 8'h86);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    ctrl(1'b1, 1'b1);
    cmp1(buffered_mode_o, 1'b1);
    // count touched only in buffered mode
    foreach (cvals[i]) begin
      v = cvals[i];
      wr(8'h00, v);
      cmp1(count_invalid_o, v[6:0] == 7'h00 || v[6:0] > BYTE_COUNT_MAX);
      ctrl(1'b1, v[6:0] == 7'h00 || v[6:0] > BYTE_COUNT_MAX);
      rd(8'h00, v);
    end
    wr(8'h00, 8'h81);
    buffered_rx_i = 1;
    repeat (2) @(negedge clk_i);
    cmp1(last_byte_ack_o, 1'b0);
    wr(8'h00, 8'h01);
    repeat (2) @(negedge clk_i);
    cmp1(last_byte_ack_o, 1'b1);
    wr(8'h00, 8'h85);
    repeat (4) begin
      @(negedge clk_i);
      byte_stored_i = 1;
      @(negedge clk_i);
      byte_stored_i = 0;
    end
    @(negedge clk_i);
    cmp1(last_byte_ack_o, 1'b0);
    rd(8'h00, 8'h84);
    buffered_rx_i = 0;
    a = $random(seed);
    av = {(a[7:1] == 7'h00) ? 7'h01 : a[7:1], 1'b1};
    wr(8'h01, av);
    addr({av[7:1], a[0]}, 1'b1, 1'b0);
    addr({av[7:1] ^ 7'h40, 1'b0}, 1'b0, 1'b0);
    addr(GENERAL_CALL, 1'b0, 1'b1);
    rd(8'h01, av);
    // A write while the clock enable is low must leave every register as it was.
    ce_i = 0;
    wr(8'h01, 8'h5A);
    ce_i = 1;
    rd(8'h01, av);
    wr(8'h01, {av[7:1], 1'b0});
    addr(GENERAL_CALL, 1'b0, 1'b0);
    // own address ignored in master mode
    master_i = 1;
    addr({av[7:1], 1'b0}, 1'b0, 1'b0);
    ctrl(1'b0, 1'b0);
    cmp1(buffered_mode_o, 1'b0);
    wr(8'h02, 8'h10);
    rd(8'h02, MIN_LOW_STD);
    wr(8'h06, 8'h03);
    wr(8'h02, 8'h01);
    rd(8'h02, MIN_LOW_TURBO);
    wr(8'h02, 8'h20);
    wr(8'h03, 8'h10);
    rd(8'h03, 8'h10);
    meas(1'b1, n);
    meas(1'b1, n);
    cmp1(n >= 32 * T && n <= 32 * T + 2, 1'b1);
    meas(1'b0, n);
    cmp1(n >= 16 * T && n <= 16 * T + 5, 1'b1);
    stretch = 1;
    meas(1'b0, n);
    cmp1(n > 16 * T + 20, 1'b1);
    stretch = 0;
    repeat (4) @(negedge clk_i);
    close_out();
  end
endmodule

// ===== hw/icar_regs.sv
// Indirect byte count, own address and SCL rate registers with address match and SCL timing.
//
// Summary of operation
// (R1) Count reports bytes stored on receive, bytes to send on transmit.
// (R2) Last-byte bit set: final received byte is not acknowledged.
// (R3) Last-byte bit clear: final byte acknowledged; later transfer must end read.
// (R4) Seven-bit count field sets buffered transfer length, up to 68.
// (R5) Count zero or above 68: move nothing, flag done at control write.
// (R6) Host touches the byte count only in buffered mode.
// (R7) Own address changes only by host writes, never by hardware.
// (R8) Own address is ignored in any master mode.
// (R9) Host never addresses its own slave address as master.
// (R10) Slave compares address bits 7:1 with received bits, MSB first.
// (R11) Address bit 0 enables response to General Call 00h.
// (R12) Host programs a non-zero own slave address.
// (R13) Own address reads E0h after reset.
// (R14) SCL high and low times are rate values times oscillator period.
// (R15) Low rate register sets SCL low time in oscillator periods.
// (R16) High rate register sets SCL high time in oscillator periods.
// (R17) Standard-mode timing is selected after reset.
// (R18) Host sets speed mode before writing the rate registers.
// (R19) Pointer selects the indirect register reached through the data window.
// (R20) Control mode bit: zero is byte mode, one is buffered mode.
// (R21) Rate values below the mode minimum load the minimum instead.
// (R22) SCL generator counts low period, releases, counts high, drives low.
`timescale 1ns/1ps
module icar_regs
  import icar_pkg::*;
#(
  parameter int TICK_CYCLES = OSC_TICK_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       ptr_wr_i,
  input  wire logic       data_wr_i,
  input  wire logic       data_rd_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic      [7:0] ptr_o,
  input  wire logic       ctrl_wr_i,
  input  wire logic       master_i,
  input  wire logic       buffered_rx_i,
  input  wire logic       byte_stored_i,
  input  wire logic       byte_sent_i,
  input  wire logic       addr_valid_i,
  input  wire logic [7:0] addr_byte_i,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  output logic            buffered_mode_o,
  output logic            count_invalid_o,
  output logic            count_done_irq_o,
  output logic            last_byte_ack_o,
  output logic            own_match_o,
  output logic            gc_match_o
);
  initial begin
    if (TICK_CYCLES < 1) $error("icar_regs: TICK_CYCLES must be at least one");
  end

  logic [7:0]  ptr_reg;
  logic [7:0]  ptr_next;
  logic [7:0]  count_reg;
  logic [7:0]  count_next;
  logic [7:0]  xfer_reg;
  logic [7:0]  xfer_next;
  logic [6:0]  target_reg;
  logic [6:0]  target_next;
  logic [7:0]  addr_reg;
  logic [7:0]  addr_next;
  logic [7:0]  low_reg;
  logic [7:0]  low_next;
  logic [7:0]  high_reg;
  logic [7:0]  high_next;
  icar_speed_t speed_reg;
  icar_speed_t speed_next;
  logic        mode_reg;
  logic        mode_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        irq_reg;
  logic        irq_next;
  logic        own_reg;
  logic        own_next;
  logic        gc_reg;
  logic        gc_next;
  logic        ack_reg;
  logic        ack_next;
  logic [7:0]  min_low;
  logic [7:0]  min_high;
  logic        count_bad;
  logic        scl_sync;
  logic        scl_drive_low;

  // The SCL pin is outside the clock domain.
  icar_sync #(
    .WIDTH(1)
  ) u_scl_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i (ce_i),
    .d_i  (scl_i),
    .q_o  (scl_sync)
  );

  // (R21) minimum per speed mode
  always_comb begin
    case (speed_reg)
      ICAR_SPEED_STD: begin
        min_low  = MIN_LOW_STD;
        min_high = MIN_HIGH_STD;
      end
      ICAR_SPEED_FAST: begin
        min_low  = MIN_LOW_FAST;
        min_high = MIN_HIGH_FAST;
      end
      ICAR_SPEED_FMP: begin
        min_low  = MIN_LOW_FMP;
        min_high = MIN_HIGH_FMP;
      end
      ICAR_SPEED_TURBO: begin
        min_low  = MIN_LOW_TURBO;
        min_high = MIN_HIGH_TURBO;
      end
      default: begin
        min_low  = MIN_LOW_STD;
        min_high = MIN_HIGH_STD;
      end
    endcase
  end

  // (R4) valid count range
  assign count_bad = (count_reg[6:0] == 7'h00) || (count_reg[6:0] > BYTE_COUNT_MAX);

  always_comb begin
    ptr_next   = ptr_reg;
    count_next = count_reg;
    xfer_next  = xfer_reg;
    target_next = target_reg;
    addr_next  = addr_reg;
    low_next   = low_reg;
    high_next  = high_reg;
    speed_next = speed_reg;
    mode_next  = mode_reg;
    rdata_next = rdata_reg;
    irq_next   = 1'b0;
    // (R19) pointer then window
    if (ptr_wr_i) begin
      ptr_next = wdata_i;
    end
    if (data_wr_i) begin
      case (ptr_reg)
        // The count field is rewritten as bytes are stored, so the length is kept apart.
        IDX_BYTE_COUNT: begin
          count_next  = wdata_i;
          target_next = wdata_i[6:0];
        end
        // (R7) host write only
        IDX_OWN_ADDR:   addr_next  = wdata_i;
        IDX_SCL_LOW:    low_next   = (wdata_i < min_low) ? min_low : wdata_i;
        IDX_SCL_HIGH:   high_next  = (wdata_i < min_high) ? min_high : wdata_i;
        IDX_SPEED_MODE: speed_next = icar_speed_t'(wdata_i[1:0]);
        default:        ;
      endcase
    end
    if (data_rd_i) begin
      case (ptr_reg)
        IDX_BYTE_COUNT: rdata_next = count_reg;
        IDX_OWN_ADDR:   rdata_next = addr_reg;
        IDX_SCL_LOW:    rdata_next = low_reg;
        IDX_SCL_HIGH:   rdata_next = high_reg;
        IDX_SPEED_MODE: rdata_next = {6'h00, speed_reg};
        default:        rdata_next = 8'h00;
      endcase
    end
    if (ctrl_wr_i) begin
      // (R20) mode bit
      mode_next = wdata_i[CTRL_MODE_BIT];
      xfer_next = 8'h00;
      // (R5) immediate completion on bad count
      irq_next  = wdata_i[CTRL_MODE_BIT] && count_bad;
    end else if (mode_reg && (byte_stored_i || byte_sent_i)) begin
      // (R1) count stored or sent bytes
      xfer_next = xfer_reg + 8'h01;
      if (byte_stored_i && !data_wr_i) begin
        count_next = {count_reg[LAST_BYTE_BIT], 7'(xfer_reg[6:0] + 7'h01)};
      end
    end
  end

  // (R17) standard mode after reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_reg   <= 8'h00;
      count_reg <= RST_BYTE_COUNT;
      xfer_reg  <= 8'h00;
      target_reg <= RST_BYTE_COUNT[6:0];
      // (R13) own address default
      addr_reg  <= RST_OWN_ADDR;
      low_reg   <= RST_SCL_LOW;
      high_reg  <= RST_SCL_HIGH;
      speed_reg <= ICAR_SPEED_STD;
      mode_reg  <= 1'b0;
      rdata_reg <= 8'h00;
      irq_reg   <= 1'b0;
    end else if (ce_i) begin
      ptr_reg   <= ptr_next;
      count_reg <= count_next;
      xfer_reg  <= xfer_next;
      target_reg <= target_next;
      addr_reg  <= addr_next;
      low_reg   <= low_next;
      high_reg  <= high_next;
      speed_reg <= speed_next;
      mode_reg  <= mode_next;
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
    end
  end

  always_comb begin
    // (R8) address unused as master
    // (R10) seven-bit compare
    own_next = addr_valid_i && !master_i && (addr_byte_i[7:1] == addr_reg[7:1]);
    // (R11) general call enable
    gc_next  = addr_valid_i && !master_i && addr_reg[GC_ENABLE_BIT]
               && (addr_byte_i[7:1] == GENERAL_CALL[7:1]);
    // (R2) withhold ack on last byte
    // (R3) ack last byte when clear
    ack_next = !(buffered_rx_i && (xfer_reg[6:0] + 7'h01 == target_reg)
               && count_reg[LAST_BYTE_BIT]);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      own_reg <= 1'b0;
      gc_reg  <= 1'b0;
      ack_reg <= 1'b1;
    end else if (ce_i) begin
      own_reg <= own_next;
      gc_reg  <= gc_next;
      ack_reg <= ack_next;
    end
  end

  // (R14) ticks of oscillator period
  icar_scl_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_scl_gen (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .run_i          (master_i),
    .scl_in_i       (scl_sync),
    .low_period_i   (low_reg),
    .high_period_i  (high_reg),
    .scl_drive_low_o(scl_drive_low),
    .tick_o         ()
  );

  // Open-drain SCL: only ever pulled low.
  assign scl_o            = 1'b0;
  assign scl_oe_o         = scl_drive_low;
  assign rdata_o          = rdata_reg;
  assign ptr_o            = ptr_reg;
  assign buffered_mode_o  = mode_reg;
  assign count_invalid_o  = count_bad;
  assign count_done_irq_o = irq_reg;
  assign last_byte_ack_o  = ack_reg;
  assign own_match_o      = own_reg;
  assign gc_match_o       = gc_reg;

  chk_own_addr_hold: assert property (@(posedge clk_i) disable iff (rst_i) // (R7)
    !(ce_i && data_wr_i && ptr_reg == IDX_OWN_ADDR) |=> $stable(addr_reg))
    else $error("own address changed without a host write");

  chk_master_no_match: assert property (@(posedge clk_i) disable iff (rst_i) // (R8)
    (ce_i && master_i) |=> !own_reg && !gc_reg)
    else $error("address match reported in master mode");

  chk_bad_count_irq: assert property (@(posedge clk_i) disable iff (rst_i) // (R5)
    (ce_i && ctrl_wr_i && wdata_i[CTRL_MODE_BIT] && count_bad) |=> irq_reg)
    else $error("bad count did not complete at once");

  chk_gc_disabled: assert property (@(posedge clk_i) disable iff (rst_i) // (R11)
    !addr_reg[GC_ENABLE_BIT] && !(ce_i && data_wr_i) |=> !gc_reg)
    else $error("general call answered while disabled");

  chk_low_minimum: assert property (@(posedge clk_i) disable iff (rst_i) // (R21)
    (ce_i && data_wr_i && ptr_reg == IDX_SCL_LOW) |=> low_reg >= $past(min_low))
    else $error("low period below the mode minimum");

  chk_high_minimum: assert property (@(posedge clk_i) disable iff (rst_i) // (R21)
    (ce_i && data_wr_i && ptr_reg == IDX_SCL_HIGH) |=> high_reg >= $past(min_high))
    else $error("high period below the mode minimum");

  chk_window_read: assert property (@(posedge clk_i) disable iff (rst_i) // (R19)
    (ce_i && data_rd_i && ptr_reg == IDX_OWN_ADDR && !data_wr_i) |=> rdata_o == $past(addr_reg))
    else $error("window read did not return the selected register");

  chk_scl_low_hold: assert property (@(posedge clk_i) disable iff (rst_i) // (R15)
    $rose(scl_oe_o) && ce_i && master_i |-> scl_oe_o [*3])
    else $error("SCL low phase too short");

  chk_mode_bit: assert property (@(posedge clk_i) disable iff (rst_i) // (R20)
    (ce_i && ctrl_wr_i) |=> buffered_mode_o == $past(wdata_i[CTRL_MODE_BIT]))
    else $error("mode bit not taken from control write");
endmodule

// ===== hw/icar_scl_gen.sv
// Master SCL generator counting oscillator ticks through the low and high periods.
`timescale 1ns/1ps
module icar_scl_gen
  import icar_pkg::*;
#(
  parameter int TICK_CYCLES = OSC_TICK_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       run_i,
  input  wire logic       scl_in_i,
  input  wire logic [7:0] low_period_i,
  input  wire logic [7:0] high_period_i,
  output logic            scl_drive_low_o,
  output logic            tick_o
);
  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES > 255) $error("icar_scl_gen: TICK_CYCLES out of range");
  end

  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       low_reg;
  logic       low_next;
  logic       tick;

  assign tick = (div_reg == 8'(TICK_CYCLES - 1));

  always_comb begin
    div_next = div_reg;
    cnt_next = cnt_reg;
    low_next = low_reg;
    if (!run_i) begin
      div_next = 8'h00;
      cnt_next = 8'h00;
      low_next = 1'b0;
    end else begin
      div_next = tick ? 8'h00 : div_reg + 8'h01;
      if (tick) begin
        // (R22) low then high count
        // (R15) low phase length
        if (low_reg && cnt_reg >= low_period_i - 8'h01) begin
          low_next = 1'b0;
          cnt_next = 8'h00;
        end else if (!low_reg && !scl_in_i) begin
          // A slave holding SCL low stretches the high phase; wait until it lets go.
          cnt_next = 8'h00;
        end else if (!low_reg && cnt_reg >= high_period_i - 8'h01) begin
          // (R16) high phase length
          low_next = 1'b1;
          cnt_next = 8'h00;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= 8'h00;
      cnt_reg <= 8'h00;
      low_reg <= 1'b0;
    end else if (ce_i) begin
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      low_reg <= low_next;
    end
  end

  assign scl_drive_low_o = low_reg;
  assign tick_o          = tick & run_i;
endmodule

// ===== hw/icar_sync.sv
// Two flip-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
module icar_sync
  import icar_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  initial begin
    if (WIDTH < 1) $error("icar_sync: WIDTH must be at least one");
  end

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  always_comb begin
    meta_next = ce_i ? d_i : meta_reg;
    q_next    = ce_i ? meta_reg : q_reg;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule

// ===== shared/icar_pkg.sv
// Package with register map, field layout and timing constants for the indirect register block.
package icar_pkg;

  localparam logic [7:0] IDX_BYTE_COUNT  = 8'h00;
  localparam logic [7:0] IDX_OWN_ADDR    = 8'h01;
  localparam logic [7:0] IDX_SCL_LOW     = 8'h02;
  localparam logic [7:0] IDX_SCL_HIGH    = 8'h03;
  localparam logic [7:0] IDX_SPEED_MODE  = 8'h06;

  localparam int         LAST_BYTE_BIT   = 7;
  localparam int         GC_ENABLE_BIT   = 0;
  localparam int         CTRL_MODE_BIT   = 0;
  localparam logic [6:0] BYTE_COUNT_MAX  = 7'h44;

  localparam logic [7:0] RST_BYTE_COUNT  = 8'h00;
  localparam logic [7:0] RST_OWN_ADDR    = 8'hE0;
  localparam logic [7:0] RST_SCL_LOW     = 8'h9D;
  localparam logic [7:0] RST_SCL_HIGH    = 8'h86;
  localparam logic [1:0] RST_SPEED_MODE  = 2'h0;

  localparam logic [7:0] GENERAL_CALL    = 8'h00;

  // Least SCL period per speed mode: standard, fast, fast-plus, turbo.
  localparam logic [7:0] MIN_LOW_STD     = 8'h9D;
  localparam logic [7:0] MIN_HIGH_STD    = 8'h86;
  localparam logic [7:0] MIN_LOW_FAST    = 8'h2C;
  localparam logic [7:0] MIN_HIGH_FAST   = 8'h14;
  localparam logic [7:0] MIN_LOW_FMP     = 8'h11;
  localparam logic [7:0] MIN_HIGH_FMP    = 8'h09;
  localparam logic [7:0] MIN_LOW_TURBO   = 8'h0E;
  localparam logic [7:0] MIN_HIGH_TURBO  = 8'h05;

  // Oscillator tick period in ps and the clock period; tick count rounds down, at least one.
  localparam int         OSC_PERIOD_PS   = 35000;
  localparam int         CLK_PERIOD_PS   = 10000;
  localparam int         OSC_TICK_CYCLES = (OSC_PERIOD_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                           (OSC_PERIOD_PS / CLK_PERIOD_PS);

  typedef enum logic [1:0] {
    ICAR_SPEED_STD,
    ICAR_SPEED_FAST,
    ICAR_SPEED_FMP,
    ICAR_SPEED_TURBO
  } icar_speed_t;

endpackage
